//--- rtl/sbst_pkg.sv
// shared constants, types and decode helpers of the memory boundary-scan test port
// How it works
// - controller steps on each rising tck, next state picked only by tms
// - scan paths: 3-bit instruction, 1-bit bypass, 32-bit id, 85-cell boundary
// - narrow variant boundary register between tdi and tdo is 89 cells
// - id word holds revision 31:29, depth 28:24, width 23:18, device 17:12
// - id bits 11:1 carry maker code, bit 0 always reads one
// - code 000 captures ring, selects boundary register, drives memory outputs from its update latches
// - code 001 loads fixed id word and selects it; memory unaffected
// - code 010 captures ring, selects boundary register, floats every output driver
// - code 100 captures ring, selects boundary register, memory untouched
// - code 111 selects only the single bypass cell; memory unaffected
// - tdi sampled on rising tck, tdo changes on falling tck
// - five tms-high edges or power-up reset controller and select id instruction
// - capture-instruction state loads 01 into two low instruction stages
// - last boundary cell presets high; under external test high drives, low floats
package sbst_pkg;

  // ==========================================================================
  // scan path sizes
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN_WIDE = 85;
  localparam int BSR_LEN_NARROW = 89;
  localparam int BSR_PIN_MAX = BSR_LEN_NARROW - 1;

  // ==========================================================================
  // id word layout
  localparam int ID_REV_LSB = 29;
  localparam int ID_DEPTH_LSB = 24;
  localparam int ID_WIDTH_LSB = 18;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int ID_PRESENT_BIT = 0;
  localparam logic ID_PRESENT_VAL = 1'h1;
  // identity defaults; the values are arbitrary
  localparam logic [2:0] ID_REV_DFLT = 3'h0;
  localparam logic [4:0] ID_DEPTH_DFLT = 5'h1a;
  localparam logic [5:0] ID_WIDTH_DFLT = 6'h2c;
  localparam logic [5:0] ID_DEV_DFLT = 6'h3a;
  localparam logic [10:0] ID_MFR_DFLT = 11'h5a5;

  // ==========================================================================
  // instruction codes and reset or capture values
  localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_LEN-1:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
  localparam logic [IR_LEN-1:0] IR_RESET_VAL = INS_IDCODE;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic BYP_CAPTURE_VAL = 1'h0;
  localparam logic BSR_CTL_PRESET = 1'h1;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_type;

  typedef enum logic [1:0] {PATH_BSR, PATH_ID, PATH_BYP} sbst_path_type;

  typedef struct packed {
    logic drive_en;
    logic out_hiz;
    logic [BSR_PIN_MAX-1:0] drive_data;
  } sbst_mem_ctl_type;

  // reserved codes fall back to bypass so the chain length stays defined
  function automatic sbst_path_type sbst_path_of(input logic [IR_LEN-1:0] ins);
    unique case (ins)
      INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE: sbst_path_of = PATH_BSR;
      INS_IDCODE: sbst_path_of = PATH_ID;
      INS_BYPASS: sbst_path_of = PATH_BYP;
      default: sbst_path_of = PATH_BYP;
    endcase
  endfunction : sbst_path_of

endpackage : sbst_pkg

//--- rtl/sbst_fsm.sv
// sixteen-state test controller clocked by tck
`timescale 1ns/1ps
module sbst_fsm (
  // test clock and power-up reset
  input wire logic tck,
  input wire logic rst_n,
  // mode select
  input wire logic tms,
  // controller state
  output sbst_pkg::sbst_state_type state
);
  import sbst_pkg::*;

  sbst_state_type state_ff;
  sbst_state_type nxt_state;

  // ==========================================================================
  // transition graph
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: nxt_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state = state_ff;

endmodule : sbst_fsm

//--- rtl/sbst_bsr.sv
// boundary scan register: shift stages plus update latches
`timescale 1ns/1ps
module sbst_bsr #(
  parameter int LEN = 85
) (
  // test clock and power-up reset
  input wire logic tck,
  input wire logic rst_n,
  // serial path
  input wire logic tdi,
  output logic so,
  // synchronised ring values, cells 0 to LEN-2
  input wire logic [LEN-2:0] ring,
  // controller strobes
  input wire logic tap_reset,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  // latched parallel outputs
  output logic [LEN-1:0] upd
);
  import sbst_pkg::*;

  localparam logic [LEN-1:0] PRESET = {BSR_CTL_PRESET, {(LEN-1){1'b0}}};

  logic [LEN-1:0] sh_ff;
  logic [LEN-1:0] nxt_sh;
  logic [LEN-1:0] upd_ff;
  logic [LEN-1:0] nxt_upd;

  // ==========================================================================
  // cells; msb faces tdi, lsb faces tdo
  generate
    for (genvar i = 0; i < LEN; i++) begin : g_cell
      logic par;
      logic ser;
      if (i == LEN - 1) begin : g_ctl
        assign par = upd_ff[i];
        assign ser = tdi;
      end else begin : g_pin
        assign par = ring[i];
        assign ser = sh_ff[i+1];
      end
      always_comb begin
        nxt_sh[i] = sh_ff[i];
        if (tap_reset) begin
          nxt_sh[i] = PRESET[i];
        end else if (capture) begin
          nxt_sh[i] = par;
        end else if (shift) begin
          nxt_sh[i] = ser;
        end
        nxt_upd[i] = tap_reset ? PRESET[i] : (update ? sh_ff[i] : upd_ff[i]);
      end
    end
  endgenerate

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= PRESET;
      upd_ff <= PRESET;
    end else begin
      sh_ff <= nxt_sh;
      upd_ff <= nxt_upd;
    end
  end

  assign so = sh_ff[0];
  assign upd = upd_ff;

endmodule : sbst_bsr

//--- rtl/sbst_tap.sv
// top of the memory boundary-scan test port with its crossing to the memory clock
`timescale 1ns/1ps
module sbst_tap #(
  parameter bit NARROW = 1'b0,
  parameter logic [2:0] ID_REV = sbst_pkg::ID_REV_DFLT,
  parameter logic [4:0] ID_DEPTH = sbst_pkg::ID_DEPTH_DFLT,
  parameter logic [5:0] ID_WIDTH = sbst_pkg::ID_WIDTH_DFLT,
  parameter logic [5:0] ID_DEV = sbst_pkg::ID_DEV_DFLT,
  parameter logic [10:0] ID_MFR = sbst_pkg::ID_MFR_DFLT,
  localparam int BSR_LEN = NARROW ? sbst_pkg::BSR_LEN_NARROW : sbst_pkg::BSR_LEN_WIDE
) (
  // memory clock and power-up reset
  input wire logic clk,
  input wire logic rst_n,
  // test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // i/o ring values seen at the balls
  input wire logic [BSR_LEN-2:0] ring_in,
  // memory-side control, clk domain
  output sbst_pkg::sbst_mem_ctl_type mem_ctl
);
  import sbst_pkg::*;

  // ==========================================================================
  // controller
  sbst_state_type state;

  sbst_fsm u_fsm (
    .tck(tck),
    .rst_n(rst_n),
    .tms(tms),
    .state(state)
  );

  logic in_reset;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;

  always_comb begin
    in_reset = (state == ST_RESET);
    cap_dr = (state == ST_CAP_DR);
    sh_dr = (state == ST_SH_DR);
    upd_dr = (state == ST_UPD_DR);
    cap_ir = (state == ST_CAP_IR);
    sh_ir = (state == ST_SH_IR);
    upd_ir = (state == ST_UPD_IR);
  end

  // ==========================================================================
  // instruction register
  logic [IR_LEN-1:0] ir_sh_ff;
  logic [IR_LEN-1:0] nxt_ir_sh;
  logic [IR_LEN-1:0] ir_ff;
  logic [IR_LEN-1:0] nxt_ir;
  sbst_path_type path;

  always_comb begin
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    if (cap_ir) begin
      nxt_ir_sh = IR_CAPTURE_VAL;
    end else if (sh_ir) begin
      nxt_ir_sh = {tdi, ir_sh_ff[IR_LEN-1:1]};
    end
    if (in_reset) begin
      nxt_ir = IR_RESET_VAL;
    end else if (upd_ir) begin
      // a reserved code still loads; it only ever selects bypass
      nxt_ir = ir_sh_ff;
    end
    path = sbst_path_of(ir_ff);
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_ff <= IR_CAPTURE_VAL;
      ir_ff <= IR_RESET_VAL;
    end else begin
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
    end
  end

  // ==========================================================================
  // id word and bypass cell
  logic [ID_LEN-1:0] id_word;
  logic [ID_LEN-1:0] id_sh_ff;
  logic [ID_LEN-1:0] nxt_id_sh;
  logic byp_ff;
  logic nxt_byp;

  always_comb begin
    id_word = '0;
    id_word[ID_REV_LSB +: 3] = ID_REV;
    id_word[ID_DEPTH_LSB +: 5] = ID_DEPTH;
    id_word[ID_WIDTH_LSB +: 6] = ID_WIDTH;
    id_word[ID_DEV_LSB +: 6] = ID_DEV;
    id_word[ID_MFR_LSB +: 11] = ID_MFR;
    id_word[ID_PRESENT_BIT] = ID_PRESENT_VAL;
  end

  always_comb begin
    nxt_id_sh = id_sh_ff;
    nxt_byp = byp_ff;
    if (path == PATH_ID) begin
      if (cap_dr) begin
        nxt_id_sh = id_word;
      end else if (sh_dr) begin
        nxt_id_sh = {tdi, id_sh_ff[ID_LEN-1:1]};
      end
    end
    if (path == PATH_BYP) begin
      if (cap_dr) begin
        nxt_byp = BYP_CAPTURE_VAL;
      end else if (sh_dr) begin
        nxt_byp = tdi;
      end
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      id_sh_ff <= '0;
      byp_ff <= BYP_CAPTURE_VAL;
    end else begin
      id_sh_ff <= nxt_id_sh;
      byp_ff <= nxt_byp;
    end
  end

  // ==========================================================================
  // ring synchroniser; the balls move on the memory clock, not on tck
  logic [BSR_LEN-2:0] ring_s1_ff;
  logic [BSR_LEN-2:0] ring_s2_ff;

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ring_s1_ff <= '0;
      ring_s2_ff <= '0;
    end else begin
      ring_s1_ff <= ring_in;
      ring_s2_ff <= ring_s1_ff;
    end
  end

  // ==========================================================================
  // boundary register
  logic bsr_sel;
  logic bsr_so;
  logic [BSR_LEN-1:0] bsr_upd;

  assign bsr_sel = (path == PATH_BSR);

  sbst_bsr #(
    .LEN(BSR_LEN)
  ) u_bsr (
    .tck(tck),
    .rst_n(rst_n),
    .tdi(tdi),
    .so(bsr_so),
    .ring(ring_s2_ff),
    .tap_reset(in_reset),
    .capture(cap_dr && bsr_sel),
    .shift(sh_dr && bsr_sel),
    .update(upd_dr && bsr_sel),
    .upd(bsr_upd)
  );

  // ==========================================================================
  // serial output, launched on the falling edge
  logic nxt_tdo;
  logic nxt_tdo_oe;
  logic tdo_ff;
  logic tdo_oe_ff;

  always_comb begin
    nxt_tdo = 1'b0;
    nxt_tdo_oe = sh_ir || sh_dr;
    if (sh_ir) begin
      nxt_tdo = ir_sh_ff[0];
    end else if (sh_dr) begin
      unique case (path)
        PATH_BSR: nxt_tdo = bsr_so;
        PATH_ID: nxt_tdo = id_sh_ff[0];
        PATH_BYP: nxt_tdo = byp_ff;
      endcase
    end
  end

  // outside the shift states the pin floats, so power-up leaves it high-z
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ==========================================================================
  // memory-side control word, built in the tck domain
  sbst_mem_ctl_type want;

  always_comb begin
    want = '0;
    want.drive_en = (ir_ff == INS_EXTEST);
    want.drive_data[BSR_LEN-2:0] = bsr_upd[BSR_LEN-2:0];
    unique case (ir_ff)
      INS_EXTEST: want.out_hiz = !bsr_upd[BSR_LEN-1];
      INS_SAMPLE_Z: want.out_hiz = 1'b1;
      default: want.out_hiz = 1'b0;
    endcase
  end

  // ==========================================================================
  // toggle handshake, tck side; the held word stays still while a request flies
  sbst_mem_ctl_type hold_ff;
  sbst_mem_ctl_type nxt_hold;
  logic req_ff;
  logic nxt_req;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic ack_ff;

  always_comb begin
    nxt_hold = hold_ff;
    nxt_req = req_ff;
    if ((req_ff == ack_s2_ff) && (want != hold_ff)) begin
      nxt_hold = want;
      nxt_req = !req_ff;
    end
  end

  // a change made just before tck stops waits for the next tck edge to launch
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= '0;
      req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      req_ff <= nxt_req;
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ==========================================================================
  // toggle handshake, memory clock side
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  logic nxt_ack;
  sbst_mem_ctl_type ctl_ff;
  sbst_mem_ctl_type nxt_ctl;

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_ack = ack_ff;
    if (req_s2_ff != req_s3_ff) begin
      nxt_ctl = hold_ff;
      nxt_ack = req_s2_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
      ack_ff <= 1'b0;
      ctl_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      ack_ff <= nxt_ack;
      ctl_ff <= nxt_ctl;
    end
  end

  assign mem_ctl = ctl_ff;

endmodule : sbst_tap

//--- bench/sbst_tap_checker.sv
// port assertions of the memory boundary-scan test port
`timescale 1ns/1ps
module sbst_tap_checker #(
  parameter bit NARROW = 1'b0
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  // test link
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  // memory side
  input wire sbst_pkg::sbst_mem_ctl_type mem_ctl
);
  import sbst_pkg::*;
  // ====================
  // helper state
  logic [1:0] out_rise_ff;
  logic [2:0] tck_sync_ff;
  logic [3:0] quiet_ff;
  logic [2:0] nxt_tck_sync;
  logic [3:0] nxt_quiet;
  // tdo as seen at the last rising tck
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      out_rise_ff <= 2'h0;
    end else begin
      out_rise_ff <= {tdo, tdo_oe};
    end
  end
  // clk cycles since tck last moved; saturates so it never wraps
  always_comb begin
    nxt_tck_sync = {tck_sync_ff[1:0], tck};
    nxt_quiet = (quiet_ff == 4'hf) ? quiet_ff : quiet_ff + 4'h1;
    if (tck_sync_ff[2] != tck_sync_ff[1]) begin
      nxt_quiet = 4'h0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_sync_ff <= 3'h0;
      quiet_ff <= 4'h0;
    end else begin
      tck_sync_ff <= nxt_tck_sync;
      quiet_ff <= nxt_quiet;
    end
  end
  // ====================
  // assertions
  sequence five_high_s;
    tms [*5];
  endsequence
  out_on_fall_a: assert property (@(negedge tck) disable iff (!rst_n)
    {tdo, tdo_oe} == out_rise_ff) else $error("tdo moved off a falling tck");
  idle_low_a: assert property (@(posedge tck) disable iff (!rst_n)
    !tdo_oe |-> !tdo) else $error("tdo high while not driving");
  tap_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
    five_high_s |=> !tdo_oe [*2]) else $error("tdo enabled after tms reset");
  reach_shift_a: assert property (@(posedge tck) disable iff (!rst_n)
    five_high_s ##1 !tms [*3] ##1 tms ##1 !tms [*2] |=> tdo_oe)
    else $error("shift not reached from reset");
  shift_hold_a: assert property (@(posedge tck) disable iff (!rst_n)
    tdo_oe && !tms |=> tdo_oe) else $error("shift left with tms low");
  shift_leave_a: assert property (@(posedge tck) disable iff (!rst_n)
    $fell(tdo_oe) |-> $past(tms)) else $error("shift left without tms high");
  mem_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    quiet_ff == 4'hf |-> $stable(mem_ctl)) else $error("memory control moved, tck still");
  wide_cells_a: assert property (@(posedge clk) disable iff (!rst_n)
    !NARROW |-> mem_ctl.drive_data[87:84] == 4'h0) else $error("wide variant extra cells");
endmodule : sbst_tap_checker

bind sbst_tap sbst_tap_checker #(.NARROW(NARROW)) sbst_tap_checker_inst (.clk(clk),
  .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .mem_ctl(mem_ctl));

//--- bench/sbst_tester.sv
// far-side test controller model driving the test link
`timescale 1ns/1ps
module sbst_tester (
  // test link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 6 ns tck period; tck stands still between calls
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3;
    tck = 1'b1;
    o = tdo;
    #3;
    tck = 1'b0;
  endtask : step
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    repeat (3) step(1'b0, 1'b0, o);
  endtask : tap_reset
  // from idle, scan n bits lsb first and come back to idle; codes come from the caller
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) begin
      step(1'b1, 1'b0, o);
    end
    repeat (2) step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    // idle steps carry the memory-side handshake
    repeat (3) step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask : scan
endmodule : sbst_tester

//--- bench/tb.sv
// self-checking bench of the memory boundary-scan test port
`timescale 1ns/1ps
module tb;
  import sbst_pkg::*;
  // ====================
  // constants and state
  localparam logic [127:0] PAT = {4{32'hc3a5_96e1}};
  localparam logic [83:0] RING_W = 84'h5_a5a5_c3c3_0f0f_9696_1234;
  localparam logic [87:0] RING_N = 88'h3c_a5a5_c3c3_0f0f_9696_1234;
  localparam logic [31:0] ID_EXP = {ID_REV_DFLT, ID_DEPTH_DFLT, ID_WIDTH_DFLT,
    ID_DEV_DFLT, ID_MFR_DFLT, ID_PRESENT_VAL};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pick_narrow = 1'b0;
  logic spare;
  logic [83:0] ring_w = '0;
  logic [87:0] ring_n = '0;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_w;
  logic tdo_n;
  sbst_mem_ctl_type ctl_w;
  logic [127:0] res;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sbst_tap #(.NARROW(1'b0)) sbst_tap_inst (.clk(clk), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo_w), .tdo_oe(), .ring_in(ring_w), .mem_ctl(ctl_w));
  // narrow variant shares the link; pick_narrow picks whose tdo is read
  sbst_tap #(.NARROW(1'b1)) sbst_tap_narrow_inst (.clk(clk), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo_n), .tdo_oe(), .ring_in(ring_n), .mem_ctl());
  sbst_tester sbst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi),
    .tdo(pick_narrow ? tdo_n : tdo_w));
  // ====================
  // checking helpers
  task automatic check(input string what, input logic [127:0] exp,
    input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic load_ir(input logic [2:0] code);
    sbst_tester_inst.scan(1'b1, 3, {125'h0, code}, res);
    check("ir capture", 128'h1, res);
  endtask : load_ir
  // captured bits first, then the pattern delayed by the chain length
  task automatic scan_dr(input string what, input int len, input logic [127:0] cap);
    sbst_tester_inst.scan(1'b0, 128, PAT, res);
    check(what, cap | (PAT << len), res);
  endtask : scan_dr
  task automatic check_mem(input string what, input logic [89:0] exp);
    repeat (8) @(posedge clk);
    check(what, 128'(exp), 128'(ctl_w));
  endtask : check_mem
  // ====================
  // scenarios
  task automatic t_id();
    scan_dr("power-up id", ID_LEN, ID_EXP);
  endtask : t_id
  task automatic t_codes();
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      // reserved codes are skipped here; they would load and only select bypass
      if (c == 3'h3 || c == 3'h5 || c == 3'h6) begin
        continue;
      end
      load_ir(c);
      if (c == INS_EXTEST || c == INS_SAMPLE_Z || c == INS_SAMPLE) begin
        scan_dr("boundary", BSR_LEN_WIDE, {1'b1, ring_w});
      end else if (c == INS_IDCODE) begin
        scan_dr("id", ID_LEN, ID_EXP);
      end else begin
        scan_dr("bypass", 1, 128'h0);
      end
      check_mem("ctl", {c == INS_EXTEST, c == INS_SAMPLE_Z, 4'h0, PAT[43 +: 84]});
    end
  endtask : t_codes
  task automatic t_float();
    load_ir(INS_SAMPLE);
    sbst_tester_inst.scan(1'b0, 128, ~PAT, res);
    load_ir(INS_EXTEST);
    check_mem("float", {2'b11, 4'h0, ~PAT[43 +: 84]});
    sbst_tester_inst.tap_reset();
    check_mem("reset ctl", 90'h0);
    scan_dr("reset id", ID_LEN, ID_EXP);
    load_ir(INS_EXTEST);
    check_mem("preset drive", {2'b10, 88'h0});
  endtask : t_float
  task automatic t_narrow();
    pick_narrow = 1'b1;
    load_ir(INS_SAMPLE);
    scan_dr("narrow", BSR_LEN_NARROW, {1'b1, ring_n});
    pick_narrow = 1'b0;
  endtask : t_narrow
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // ====================
  // main sequence
  initial begin
    @(posedge clk);
    ring_w <= RING_W;
    ring_n <= RING_N;
    repeat (9) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    sbst_tester_inst.tap_reset();
    t_id();
    t_codes();
    t_float();
    t_narrow();
    close_out();
  end
  // tck must tick while power-up reset is held
  initial begin
    #20;
    sbst_tester_inst.step(1'b1, 1'b0, spare);
  end
  // 18 scans, nine of 135 tck steps and nine of 11, come to some 1100 clk cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
endmodule : tb
